//--- core/beslog_pkg.sv
// Purpose: Shared constants and types of the bus error status logger
// Assumes: 32-bit APB, registers on aligned words, one clock
// Notes:   Status bit positions count within the 64-bit bank status
package beslog_pkg;

	// Register byte offsets
	localparam logic [11:0] ADDR_STATUS_LO  = 12'h000;
	localparam logic [11:0] ADDR_STATUS_HI  = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK   = 12'h00C;
	localparam logic [11:0] ADDR_CTRL       = 12'h010;

	// Bank status field positions
	localparam int WDOG_BIT      = 10;
	localparam int EXT_BUS_BIT   = 11;
	localparam int REQ_TYPE_LSB  = 19;
	localparam int ERR_CLASS_LSB = 25;
	localparam int REDUND_BIT    = 28;
	localparam int BUS_ERR_BIT   = 29;
	localparam int INIT_DRV_BIT  = 30;
	localparam int INIT_RX_BIT   = 35;
	localparam int RESP_PAR_BIT  = 36;
	localparam int SPLIT_BIT     = 37;
	localparam int TIMEOUT_BIT   = 38;
	localparam int HARD_BIT      = 42;
	// Implemented bits; everything else reads zero
	localparam logic [63:0] STATUS_IMPL_MASK = 64'h0000_0478_7FF8_0C00;
	localparam logic [63:0] STATUS_RESET     = 64'h0000_0000_0000_0000;

	// Request type codes
	localparam logic [5:0] REQ_DCACHE_READ = 6'h00;
	localparam logic [5:0] REQ_IFETCH      = 6'h02;
	localparam logic [5:0] REQ_INTACK      = 6'h0D;
	localparam logic [5:0] REQ_PARTIAL     = 6'h10;
	localparam logic [5:0] REQ_IO_READ     = 6'h18;
	localparam logic [5:0] REQ_LOCK_READ   = 6'h19;

	// Interrupt status and mask layout
	localparam int IRQ_W          = 4;
	localparam int IRQ_LOG_BIT    = 0;
	localparam int IRQ_TOUT_BIT   = 1;
	localparam int IRQ_INIT_BIT   = 2;
	localparam int IRQ_PARITY_BIT = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

	// Control: bus ratio in bits 1:0, bus init driver enable in bit 2
	localparam int CTRL_RATIO_LSB = 0;
	localparam int CTRL_INIT_EN   = 2;
	localparam logic [2:0] CTRL_RESET = 3'h4;

	// Timing counts
	localparam logic [7:0]  PRESCALE_WRAP = 8'h7F;
	localparam logic [14:0] TIMEOUT_MAX   = 15'h7FFF;
	localparam logic [14:0] TIMEOUT_RESET = 15'h0000;
	localparam logic [7:0]  PRESCALE_RESET = 8'h00;
	localparam logic [1:0]  BUSDIV_RESET  = 2'h0;

	typedef enum logic [2:0] {
		KIND_DCACHE_READ = 3'h0,
		KIND_IFETCH      = 3'h1,
		KIND_IO_READ     = 3'h2,
		KIND_LOCK_READ   = 3'h3,
		KIND_PART_READ   = 3'h4,
		KIND_PART_WRITE  = 3'h5,
		KIND_INTACK      = 3'h6
	} beslog_kind_e;

	typedef enum logic [2:0] {
		CLASS_HARD       = 3'h0,
		CLASS_DOUBLE     = 3'h1,
		CLASS_AERR2      = 3'h2,
		CLASS_SINGLE     = 3'h4,
		CLASS_AERR1      = 3'h5
	} beslog_class_e;

	typedef enum logic [1:0] {
		APB_IDLE = 2'b01,
		APB_DONE = 2'b10
	} beslog_apb_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} beslog_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} beslog_apb_rsp_s;

	typedef struct packed {
		logic          err_valid;
		beslog_kind_e  req_kind;
		beslog_class_e err_class;
		logic          compare_err_active;
		logic          bus_error_driven;
		logic          bus_init_driven;
		logic          bus_init_received;
		logic          resp_valid;
		logic [2:0]    resp_code;
		logic          resp_parity;
		logic          split_hard_err;
		logic          init_hard_err;
		logic          uop_retire;
		logic          core_exception;
	} beslog_evt_s;

endpackage : beslog_pkg

//--- core/beslog_top.sv
// Purpose: Logs external bus errors into a 64-bit bank status register
// Assumes: Event inputs synchronous to clk, one-cycle pulses when asserted
// Notes:   Bus clock is modelled as a tick of clk divided by 2, 3 or 4
`timescale 1ns/1ps
`default_nettype none
module beslog_top (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// APB slave
	input  wire beslog_pkg::beslog_apb_req_s apb_req,
	output var  beslog_pkg::beslog_apb_rsp_s apb_rsp,
	// Bus and core events
	input  wire beslog_pkg::beslog_evt_s     evt,
	// Interrupt and bus init drive
	output logic                             irq,
	output logic                             timeout_bus_init
);
	import beslog_pkg::*;

	typedef struct packed {
		beslog_apb_e      apb_state;
		beslog_apb_rsp_s  rsp;
		logic [63:0]      status;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic [2:0]       ctrl;
		logic [1:0]       bus_div;
		logic [7:0]       prescale;
		logic [14:0]      timeout_cnt;
		logic             irq;
		logic             bus_init;
	} beslog_state_s;

	beslog_state_s st_reg;
	beslog_state_s st_next;

	function automatic logic [5:0] beslog_req_code(input beslog_kind_e kind);
		logic [5:0] code;
		code = REQ_DCACHE_READ;
		unique case (kind)
			KIND_DCACHE_READ: code = REQ_DCACHE_READ;
			KIND_IFETCH:      code = REQ_IFETCH;
			KIND_IO_READ:     code = REQ_IO_READ;
			KIND_LOCK_READ:   code = REQ_LOCK_READ;
			KIND_PART_READ:   code = REQ_PARTIAL;
			KIND_PART_WRITE:  code = REQ_PARTIAL;
			KIND_INTACK:      code = REQ_INTACK;
			default:          code = REQ_DCACHE_READ;
		endcase
		return code;
	endfunction : beslog_req_code

	logic        apb_hit;
	logic        apb_wr;
	logic        apb_mapped;
	logic [31:0] rd_word;
	logic        bus_tick;
	logic        pre_carry;
	logic        tout_fire;
	logic        tout_clear;
	logic        parity_err;
	logic [63:0] status_set;
	logic [63:0] status_clr;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic [1:0]  ratio_max;

	always_comb begin
		st_next = st_reg;

		// Bus clock tick: ratio 0 -> 1:2, 1 -> 1:3, 2 or 3 -> 1:4
		unique case (st_reg.ctrl[CTRL_RATIO_LSB +: 2])
			2'h0:    ratio_max = 2'h1;
			2'h1:    ratio_max = 2'h2;
			default: ratio_max = 2'h3;
		endcase
		bus_tick = (st_reg.bus_div >= ratio_max);
		if (bus_tick) begin
			st_next.bus_div = BUSDIV_RESET;
		end else begin
			st_next.bus_div = st_reg.bus_div + 2'h1;
		end

		// Prescaler counts bus clock periods, carries every 128
		pre_carry = bus_tick && (st_reg.prescale == PRESCALE_WRAP);
		if (bus_tick) begin
			if (pre_carry) begin
				st_next.prescale = PRESCALE_RESET;
			end else begin
				st_next.prescale = st_reg.prescale + 8'h01;
			end
		end

		// Watchdog only runs while the bus init driver is enabled
		tout_fire = st_reg.ctrl[CTRL_INIT_EN] && pre_carry
			&& (st_reg.timeout_cnt == TIMEOUT_MAX);
		tout_clear = evt.uop_retire || evt.core_exception
			|| tout_fire || st_reg.bus_init;
		if (tout_clear) begin
			st_next.timeout_cnt = TIMEOUT_RESET;
		end else if (st_reg.ctrl[CTRL_INIT_EN] && pre_carry) begin
			st_next.timeout_cnt = st_reg.timeout_cnt + 15'h0001;
		end
		st_next.bus_init = tout_fire;

		// Responder parity: even over code lines and parity line
		parity_err = evt.resp_valid && (^{evt.resp_code, evt.resp_parity});

		// Sticky status sets from events
		status_set = 64'h0;
		status_set[INIT_RX_BIT]  = evt.bus_init_received;
		status_set[RESP_PAR_BIT] = parity_err;
		status_set[SPLIT_BIT]    = evt.split_hard_err;
		status_set[TIMEOUT_BIT]  = tout_fire;
		status_set[HARD_BIT]     = evt.init_hard_err;
		status_set[INIT_DRV_BIT] = evt.bus_init_driven || tout_fire;

		// APB decode; the answer comes one cycle into the access phase
		apb_hit = apb_req.psel && apb_req.penable && st_reg.rsp.pready;
		apb_wr  = apb_hit && apb_req.pwrite;
		apb_mapped = (apb_req.paddr == ADDR_STATUS_LO)
			|| (apb_req.paddr == ADDR_STATUS_HI)
			|| (apb_req.paddr == ADDR_IRQ_STATUS)
			|| (apb_req.paddr == ADDR_IRQ_MASK)
			|| (apb_req.paddr == ADDR_CTRL);

		// Software clears status bits by writing ones, except the timeout and own hard error flags
		status_clr = 64'h0;
		irq_clr = IRQ_RESET;
		if (apb_wr) begin
			unique case (apb_req.paddr)
				ADDR_STATUS_LO:  status_clr[31:0]  = apb_req.pwdata;
				ADDR_STATUS_HI:  status_clr[63:32] = apb_req.pwdata;
				ADDR_IRQ_STATUS: irq_clr = apb_req.pwdata[IRQ_W-1:0];
				ADDR_IRQ_MASK:   st_next.irq_mask = apb_req.pwdata[IRQ_W-1:0];
				ADDR_CTRL:       st_next.ctrl = apb_req.pwdata[2:0];
				default: begin
				end
			endcase
		end

		// Set wins over a clear in the same cycle
		st_next.status = ((st_reg.status & ~status_clr) | status_set)
			& STATUS_IMPL_MASK;

		// Error log fields overwrite on each logged error or watchdog
		if (tout_fire) begin
			st_next.status[15:0] = 16'h0;
			st_next.status[WDOG_BIT] = 1'b1;
		end else if (evt.err_valid) begin
			st_next.status[WDOG_BIT] = 1'b0;
			st_next.status[EXT_BUS_BIT] = 1'b1;
			st_next.status[REQ_TYPE_LSB +: 6] = beslog_req_code(evt.req_kind);
			st_next.status[ERR_CLASS_LSB +: 3] = evt.err_class;
			st_next.status[REDUND_BIT]   = evt.compare_err_active;
			st_next.status[BUS_ERR_BIT]  = evt.bus_error_driven;
			st_next.status[INIT_DRV_BIT] = evt.bus_init_driven;
		end
		// Timeout and own hard error flags survive any overwrite
		if (st_reg.status[TIMEOUT_BIT]) begin
			st_next.status[TIMEOUT_BIT] = 1'b1;
		end
		if (st_reg.status[HARD_BIT]) begin
			st_next.status[HARD_BIT] = 1'b1;
		end

		// Interrupt sources
		irq_set = IRQ_RESET;
		irq_set[IRQ_LOG_BIT]    = evt.err_valid;
		irq_set[IRQ_TOUT_BIT]   = tout_fire;
		irq_set[IRQ_INIT_BIT]   = evt.bus_init_received;
		irq_set[IRQ_PARITY_BIT] = parity_err;
		st_next.irq_status = (st_reg.irq_status & ~irq_clr) | irq_set;
		st_next.irq = |(st_next.irq_status & st_next.irq_mask);

		// Read mux shows reserved bits as zero
		unique case (apb_req.paddr)
			ADDR_STATUS_LO:  rd_word = st_reg.status[31:0] & STATUS_IMPL_MASK[31:0];
			ADDR_STATUS_HI:  rd_word = st_reg.status[63:32] & STATUS_IMPL_MASK[63:32];
			ADDR_IRQ_STATUS: rd_word = {28'h0, st_reg.irq_status};
			ADDR_IRQ_MASK:   rd_word = {28'h0, st_reg.irq_mask};
			ADDR_CTRL:       rd_word = {29'h0, st_reg.ctrl};
			default:         rd_word = 32'h0;
		endcase

		// Two-state answer machine
		st_next.rsp.pready = 1'b0;
		unique case (st_reg.apb_state)
			APB_IDLE: begin
				if (apb_req.psel && apb_req.penable) begin
					st_next.apb_state   = APB_DONE;
					st_next.rsp.pready  = 1'b1;
					st_next.rsp.pslverr = !apb_mapped;
					st_next.rsp.prdata  = apb_req.pwrite ? 32'h0 : rd_word;
				end
			end
			APB_DONE: begin
				st_next.apb_state   = APB_IDLE;
				st_next.rsp.pslverr = 1'b0;
				st_next.rsp.prdata  = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg.apb_state   <= APB_IDLE;
			st_reg.rsp         <= '0;
			st_reg.status      <= STATUS_RESET;
			st_reg.irq_status  <= IRQ_RESET;
			st_reg.irq_mask    <= IRQ_RESET;
			st_reg.ctrl        <= CTRL_RESET;
			st_reg.bus_div     <= BUSDIV_RESET;
			st_reg.prescale    <= PRESCALE_RESET;
			st_reg.timeout_cnt <= TIMEOUT_RESET;
			st_reg.irq         <= 1'b0;
			st_reg.bus_init    <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign apb_rsp          = st_reg.rsp;
	assign irq              = st_reg.irq;
	assign timeout_bus_init = st_reg.bus_init;

endmodule : beslog_top
`default_nettype wire

//--- verif/beslog_agent.sv
// Purpose: Responding agent driving response code and parity
// Assumes: Send is a one-cycle command
// Notes:   Idle lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module beslog_agent (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Bench commands
	input wire logic       send,
	input wire logic       bad_par,
	input wire logic [2:0] code,
	// Response lines
	output logic           resp_valid,
	output logic [2:0]     resp_code,
	output logic           resp_parity
);
	always_ff @(posedge clk) begin
		if (rst) begin
			resp_valid  <= 1'b0;
			resp_code   <= 3'h0;
			resp_parity <= 1'b0;
		end else if (send) begin
			resp_valid  <= 1'b1;
			resp_code   <= code;
			resp_parity <= ^code ^ bad_par;
		end else begin
			resp_valid  <= 1'b0;
			resp_code   <= ~resp_code;
			resp_parity <= ~resp_parity;
		end
	end
endmodule : beslog_agent
`default_nettype wire

//--- verif/beslog_sva.sv
// Purpose: Port-level checks of the bus error logger
// Assumes: One clock, synchronous reset
// Notes:   Status fields are seen only through APB reads
`timescale 1ns/1ps
`default_nettype none
module beslog_sva (
	// Clock and reset
	input wire logic                        clk,
	input wire logic                        rst,
	// Watched ports
	input wire beslog_pkg::beslog_apb_req_s apb_req,
	input wire beslog_pkg::beslog_apb_rsp_s apb_rsp,
	input wire beslog_pkg::beslog_evt_s     evt,
	input wire logic                        irq,
	input wire logic                        timeout_bus_init
);
	import beslog_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic rd_lo;
	logic rd_hi;
	logic mapped;
	assign rd_lo  = apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == ADDR_STATUS_LO;
	assign rd_hi  = apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == ADDR_STATUS_HI;
	assign mapped = apb_req.paddr inside {ADDR_STATUS_LO, ADDR_STATUS_HI, ADDR_IRQ_STATUS,
		ADDR_IRQ_MASK, ADDR_CTRL};
	AST_APB_WAIT: assert property (apb_req.psel && !apb_req.penable |-> ##2 apb_rsp.pready)
		else $error("pready late after setup");
	AST_PREADY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	AST_RDATA_IDLE: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
		else $error("read data outside answer");
	AST_SLVERR_MAP: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !mapped)
		else $error("slave error does not match address map");
	AST_LO_RSVD: assert property (rd_lo
		|-> (apb_rsp.prdata & ~STATUS_IMPL_MASK[31:0]) == 0)
		else $error("reserved low status bit set");
	AST_HI_RSVD: assert property (rd_hi
		|-> (apb_rsp.prdata & ~STATUS_IMPL_MASK[63:32]) == 0)
		else $error("reserved high status bit set");
	AST_CODE_EXCL: assert property (rd_lo && apb_rsp.prdata[EXT_BUS_BIT]
		|-> !apb_rsp.prdata[WDOG_BIT])
		else $error("bus error and watchdog code both set");
	AST_TOUT_PULSE: assert property (timeout_bus_init |=> !timeout_bus_init)
		else $error("timeout bus init longer than one cycle");
	COV_SLVERR: cover property (apb_rsp.pready && apb_rsp.pslverr);
	COV_LOG: cover property (rd_lo && apb_rsp.prdata[EXT_BUS_BIT]);
	COV_IRQ: cover property ($rose(irq));
endmodule : beslog_sva
bind beslog_top beslog_sva i_beslog_sva (.clk(clk), .rst(rst), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .evt(evt), .irq(irq), .timeout_bus_init(timeout_bus_init));
`default_nettype wire

//--- verif/bus_error_status_logger_test.sv
// Purpose: Self-checking bench for the bus error logger
// Assumes: APB answers after one wait state
// Notes:   Retirement timeout too long to run; only its quiet state is checked
`timescale 1ns/1ps
`default_nettype none
module bus_error_status_logger_test;
	import beslog_pkg::*;
	logic            clk, rst, irq, tbi, send, bad_par, rv, rp, se;
	logic [2:0]      code, rc;
	logic [31:0]     rd;
	beslog_apb_req_s req;
	beslog_apb_rsp_s rsp;
	beslog_evt_s     ev, evt, v;
	bit   [63:0]     m_st;
	bit   [3:0]      m_irq;
	int              errors, checked, k;
	localparam bit [5:0] KCODE [7] = '{6'h00, 6'h02, 6'h18, 6'h19, 6'h10, 6'h10, 6'h0D};
	localparam bit [2:0] CLS [5]   = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
	beslog_top i_beslog_top (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .evt(evt),
		.irq(irq), .timeout_bus_init(tbi));
	beslog_agent i_beslog_agent (.clk(clk), .rst(rst), .send(send), .bad_par(bad_par),
		.code(code), .resp_valid(rv), .resp_code(rc), .resp_parity(rp));
	always_comb begin
		evt = ev;
		evt.resp_valid  = rv;
		evt.resp_code   = rc;
		evt.resp_parity = rp;
	end
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_bit(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		se = rsp.pslverr;
		req <= '0;
	endtask : apb
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdc
	task automatic pulse(input beslog_evt_s p);
		@(posedge clk);
		ev <= p;
		@(posedge clk);
		ev <= '0;
	endtask : pulse
	task automatic resp(input logic bad);
		@(posedge clk);
		send    <= 1'b1;
		bad_par <= bad;
		code    <= 3'($urandom);
		@(posedge clk);
		send    <= 1'b0;
	endtask : resp
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		test_done();
	end
	initial begin
		rst = 1'b1;
		req = '0;
		ev = '0;
		{send, bad_par, code} = '0;
		{errors, checked, m_st, m_irq} = '0;
		void'($urandom(21530));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdc("status_lo", ADDR_STATUS_LO, STATUS_RESET[31:0]);
		rdc("status_hi", ADDR_STATUS_HI, STATUS_RESET[63:32]);
		rdc("irq_status", ADDR_IRQ_STATUS, 32'(IRQ_RESET));
		rdc("irq_mask", ADDR_IRQ_MASK, 32'(IRQ_RESET));
		rdc("ctrl", ADDR_CTRL, 32'(CTRL_RESET));
		rdc("unmapped", 12'h014, 32'h0);
		chk_bit("slverr", 1'b1, se);
		k = int'($urandom % 4);
		apb(1'b1, ADDR_CTRL, {29'h0, 1'b1, 2'(k)});
		rdc("ctrl", ADDR_CTRL, {29'h0, 1'b1, 2'(k)});
		$display("test reset done");
		for (k = 0; k < 7; k++) begin
			v = '0;
			v.err_valid      = 1'b1;
			v.req_kind       = beslog_kind_e'(3'(k));
			v.err_class      = beslog_class_e'(CLS[k % 5]);
			{v.compare_err_active, v.bus_error_driven, v.bus_init_driven} = 3'($urandom);
			{v.uop_retire, v.core_exception} = 2'($urandom);
			pulse(v);
			m_st[11] = 1'b1;
			m_st[24:19] = KCODE[k];
			m_st[27:25] = CLS[k % 5];
			m_st[30:28] = {v.bus_init_driven, v.bus_error_driven, v.compare_err_active};
			m_irq[0] = 1'b1;
			apb(1'b0, ADDR_STATUS_LO, 32'h0);
			chk("req_type", 32'(m_st[24:19]), 32'(rd[24:19]));
			chk("err_class", 32'(m_st[27:25]), 32'(rd[27:25]));
			chk("log_flags", 32'(m_st[30:28]), 32'(rd[30:28]));
			chk("status_lo", m_st[31:0], rd);
			apb(1'b1, ADDR_STATUS_LO, 32'hFFFF_FFFF);
			m_st[31:0] = 32'h0;
		end
		rdc("status_lo", ADDR_STATUS_LO, m_st[31:0]);
		$display("test logging done");
		resp(1'b0);
		rdc("status_hi", ADDR_STATUS_HI, m_st[63:32]);
		resp(1'b1);
		v = '0;
		v.bus_init_received = 1'b1;
		v.split_hard_err = 1'b1;
		v.init_hard_err  = 1'b1;
		pulse(v);
		m_st[37:35] = 3'h7;
		m_st[42] = 1'b1;
		m_irq[3:2] = 2'h3;
		rdc("status_hi", ADDR_STATUS_HI, m_st[63:32]);
		rdc("irq_status", ADDR_IRQ_STATUS, 32'(m_irq));
		chk_bit("irq", 1'b0, irq);
		apb(1'b1, ADDR_IRQ_MASK, 32'h4);
		repeat (2) @(posedge clk);
		chk_bit("irq", 1'b1, irq);
		apb(1'b1, ADDR_IRQ_STATUS, 32'h4);
		m_irq[2] = 1'b0;
		repeat (2) @(posedge clk);
		chk_bit("irq", 1'b0, irq);
		rdc("irq_status", ADDR_IRQ_STATUS, 32'(m_irq));
		apb(1'b1, ADDR_STATUS_HI, 32'hFFFF_FFFF);
		m_st[37:35] = 3'h0;
		rdc("status_hi", ADDR_STATUS_HI, m_st[63:32]);
		$display("test events done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdc("status_hi", ADDR_STATUS_HI, STATUS_RESET[63:32]);
		rdc("irq_status", ADDR_IRQ_STATUS, 32'(IRQ_RESET));
		rdc("ctrl", ADDR_CTRL, 32'(CTRL_RESET));
		chk_bit("irq", 1'b0, irq);
		chk_bit("bus_init", 1'b0, tbi);
		$display("test reset again done");
		test_done();
	end
endmodule : bus_error_status_logger_test
`default_nettype wire
